//--- verilog/reset_defaults_pkg.sv
// Contract
// - during reset or oscillator wait only the program counter is undefined; all else held.
// - watchdog enable register reset value comes from the option byte input.
// - converter result clears to 0000H; byte views, mode, channel, port configs to 00H.
// - three comparator control and reference registers and output flags clear to 00H.
// - asynchronous serial receive and transmit buffers load FFH.
// - asynchronous serial operation mode register loads 01H.
// - async error status, transmit status, clock select clear; baud control loads FFH.
// - asynchronous serial control register loads 16H.
// - input switch control register clears to 00H.
// - clocked serial buffer, shift, mode and clock select registers clear to 00H.
// - two-wire shift, status, flags, both controls and slave address clear to 00H.
// - two-wire low and high width registers load FFH.
// - multiplier operands clear to 00H, both product halves to 0000H.
// - request flags clear; mask and priority flags load FFH.
// - external rising and falling edge enable registers clear to 00H.
// - regulator mode control register clears to 00H.
// - watchdog flag cleared on pin, power-on, default-start; set on watchdog; held on detector.
// - detector flag set on detector reset; held on watchdog; cleared on pin, power-on, default-start.
// - detection control clears on all resets except ordinary detector reset, which keeps it.
// - detection level select behaves like detection control.
// - reset source flags clear on software read and on pin or power-on reset.
package reset_defaults_pkg;

  localparam int unsigned BANK_COUNT = 59;
  localparam int unsigned ADDR_W     = 6;

  // bank group bases
  localparam int unsigned CONV_BASE      = 0;
  localparam int unsigned CMP_BASE       = 8;
  localparam int unsigned ASYNC_BASE     = 15;
  localparam int unsigned CSI_BASE       = 24;
  localparam int unsigned TWO_WIRE_BASE  = 28;
  localparam int unsigned MULT_BASE      = 36;
  localparam int unsigned IRQ_REQ_BASE   = 42;
  localparam int unsigned IRQ_MASK_BASE  = 46;
  localparam int unsigned IRQ_PRIO_BASE  = 50;
  localparam int unsigned EXT_RISE_BASE  = 54;
  localparam int unsigned EXT_FALL_BASE  = 56;
  localparam int unsigned REG_MODE_IDX   = 58;
  localparam int unsigned IRQ_GROUP_LEN  = 4;

  // entries with non-zero defaults
  localparam int unsigned ASYNC_RX_IDX   = 15;
  localparam int unsigned ASYNC_TX_IDX   = 16;
  localparam int unsigned ASYNC_MODE_IDX = 17;
  localparam int unsigned BAUD_IDX       = 21;
  localparam int unsigned ASYNC_CTRL_IDX = 22;
  localparam int unsigned TW_LOW_IDX     = 33;
  localparam int unsigned TW_HIGH_IDX    = 34;

  // registers kept outside the bank
  localparam logic [ADDR_W-1:0] WDOG_EN_ADDR   = 6'h3B;
  localparam logic [ADDR_W-1:0] SRC_FLAGS_ADDR = 6'h3C;
  localparam logic [ADDR_W-1:0] LV_CTRL_ADDR   = 6'h3D;
  localparam logic [ADDR_W-1:0] LV_LEVEL_ADDR  = 6'h3E;

  localparam int unsigned WDOG_FLAG_BIT = 4;
  localparam int unsigned LV_FLAG_BIT   = 0;

  localparam logic [7:0] CLR_BYTE       = 8'h00;
  localparam logic [7:0] ONES_BYTE      = 8'hFF;
  localparam logic [7:0] ASYNC_MODE_RST = 8'h01;
  localparam logic [7:0] ASYNC_CTRL_RST = 8'h16;

  localparam logic [2:0] SYNC_INIT = 3'h0;
  localparam logic [2:0] SYNC_ONES = 3'h7;

  typedef enum logic [2:0] {
    SRC_NONE     = 3'b000,
    SRC_PIN      = 3'b001,
    SRC_PWR_ON   = 3'b010,
    SRC_WDOG     = 3'b011,
    SRC_LV       = 3'b100,
    SRC_LV_START = 3'b101
  } src_e;

  function automatic logic [7:0] reg_default(input int unsigned idx);
    logic [7:0] v;
    v = CLR_BYTE;
    if (idx >= IRQ_MASK_BASE && idx < IRQ_PRIO_BASE + IRQ_GROUP_LEN) begin
      v = ONES_BYTE;
    end
    if (idx == ASYNC_RX_IDX || idx == ASYNC_TX_IDX) begin
      v = ONES_BYTE;
    end
    if (idx == BAUD_IDX) begin
      v = ONES_BYTE;
    end
    if (idx == TW_LOW_IDX || idx == TW_HIGH_IDX) begin
      v = ONES_BYTE;
    end
    if (idx == ASYNC_MODE_IDX) begin
      v = ASYNC_MODE_RST;
    end
    if (idx == ASYNC_CTRL_IDX) begin
      v = ASYNC_CTRL_RST;
    end
    return v;
  endfunction

endpackage

//--- verilog/default_reg_bank.sv
`timescale 1ns/1ps
module default_reg_bank (
  // clock and reset
  input  wire logic                                     mclk,
  input  wire logic                                     resetn,
  input  wire logic                                     clk_en,
  // default load
  input  wire logic                                     load_defaults,
  // write port
  input  wire logic                                     wr_en,
  input  wire logic [reset_defaults_pkg::ADDR_W-1:0]    wr_idx,
  input  wire logic [7:0]                               wr_data,
  // read port
  input  wire logic [reset_defaults_pkg::ADDR_W-1:0]    rd_idx,
  output logic      [7:0]                               rd_data
);

  wire [7:0] mem_word [reset_defaults_pkg::BANK_COUNT];

  genvar i;
  generate
    for (i = 0; i < reset_defaults_pkg::BANK_COUNT; i++) begin : g_entry
      localparam logic [7:0] RST = reset_defaults_pkg::reg_default(i);
      wire        hit = wr_en && (wr_idx == 6'(i));
      logic [7:0] entry_ff;
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          entry_ff <= RST;
        end else if (clk_en) begin
          if (load_defaults) begin
            entry_ff <= RST;
          end else if (hit) begin
            entry_ff <= wr_data;
          end
        end
      end
      assign mem_word[i] = entry_ff;
    end
  endgenerate

  wire       rd_in_range = rd_idx < 6'(reset_defaults_pkg::BANK_COUNT);
  wire [7:0] rd_word     = rd_in_range ? mem_word[rd_idx] : reset_defaults_pkg::CLR_BYTE;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= reset_defaults_pkg::CLR_BYTE;
    end else if (clk_en) begin
      rd_data <= rd_word;
    end
  end

endmodule

//--- verilog/reset_flag_unit.sv
`timescale 1ns/1ps
module reset_flag_unit (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  // source capture
  input  wire logic                          take,
  input  wire reset_defaults_pkg::src_e      src,
  // software read clear
  input  wire logic                          rd_clear,
  // flags
  output logic [7:0]                         flags
);

  logic wdog_flag_ff;
  logic lv_flag_ff;
  logic nxt_wdog_flag;
  logic nxt_lv_flag;

  wire src_clear = (src == reset_defaults_pkg::SRC_PIN) || (src == reset_defaults_pkg::SRC_PWR_ON) ||
                   (src == reset_defaults_pkg::SRC_LV_START);

  assign nxt_wdog_flag = !take ? (rd_clear ? 1'b0 : wdog_flag_ff) :
                         (src == reset_defaults_pkg::SRC_WDOG) ? 1'b1 :
                         src_clear ? 1'b0 : wdog_flag_ff;
  assign nxt_lv_flag = !take ? (rd_clear ? 1'b0 : lv_flag_ff) :
                       (src == reset_defaults_pkg::SRC_LV) ? 1'b1 :
                       src_clear ? 1'b0 : lv_flag_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wdog_flag_ff <= 1'b0;
      lv_flag_ff   <= 1'b0;
    end else if (clk_en) begin
      wdog_flag_ff <= nxt_wdog_flag;
      lv_flag_ff   <= nxt_lv_flag;
    end
  end

  always_comb begin
    flags = reset_defaults_pkg::CLR_BYTE;
    flags[reset_defaults_pkg::WDOG_FLAG_BIT] = wdog_flag_ff;
    flags[reset_defaults_pkg::LV_FLAG_BIT]   = lv_flag_ff;
  end

endmodule

//--- verilog/reset_state_defaults.sv
`timescale 1ns/1ps
module reset_state_defaults (
  // clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   resetn,
  input  wire logic                                   clk_en,
  // reset requests from pins and analog blocks
  input  wire logic                                   ext_reset_n,
  input  wire logic                                   power_on_clear_req,
  input  wire logic                                   watchdog_unit_req,
  input  wire logic                                   lowvolt_detector_req,
  input  wire logic                                   lowvolt_default_start_req,
  // same-clock status
  input  wire logic                                   osc_wait,
  input  wire logic [7:0]                             option_wdog_en,
  // software write port
  input  wire logic                                   wr_en,
  input  wire logic [reset_defaults_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [7:0]                             wr_data,
  // software read port
  input  wire logic                                   rd_en,
  input  wire logic [reset_defaults_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [7:0]                             rd_data,
  output logic                                        rd_valid,
  // status
  output logic                                        in_reset,
  output logic                                        program_counter_undefined,
  output logic                                        defaults_loaded,
  output reset_defaults_pkg::src_e                    last_source,
  output logic      [7:0]                             watchdog_enable_reg,
  output logic      [7:0]                             lowvolt_detect_control,
  output logic      [7:0]                             lowvolt_level_select,
  output logic      [7:0]                             reset_source_flags
);

  localparam int unsigned NREQ = 5;

  // request synchronisers: three stages, level accepted when stages two and three agree
  wire  [NREQ-1:0] req_raw = {lowvolt_default_start_req, lowvolt_detector_req, watchdog_unit_req,
                              power_on_clear_req, !ext_reset_n};
  logic [NREQ-1:0] req_ok_ff;

  genvar k;
  generate
    for (k = 0; k < NREQ; k++) begin : g_sync
      logic [2:0] stage_ff;
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          stage_ff     <= reset_defaults_pkg::SYNC_INIT;
          req_ok_ff[k] <= 1'b0;
        end else if (clk_en) begin
          stage_ff <= {stage_ff[1:0], req_raw[k]};
          if (stage_ff[1] == stage_ff[2]) begin
            req_ok_ff[k] <= stage_ff[2];
          end
        end
      end
    end
  endgenerate

  wire pin_req      = req_ok_ff[0];
  wire pwr_on_req   = req_ok_ff[1];
  wire wdog_req     = req_ok_ff[2];
  wire lv_req       = req_ok_ff[3];
  wire lv_start_req = req_ok_ff[4];

  wire any_req = |req_ok_ff;

  logic in_reset_ff;
  wire  take = any_req && !in_reset_ff;

  // highest-ranking source wins when several arrive together
  reset_defaults_pkg::src_e nxt_src;
  assign nxt_src = pwr_on_req   ? reset_defaults_pkg::SRC_PWR_ON :
                   pin_req      ? reset_defaults_pkg::SRC_PIN :
                   lv_start_req ? reset_defaults_pkg::SRC_LV_START :
                   wdog_req     ? reset_defaults_pkg::SRC_WDOG :
                   lv_req       ? reset_defaults_pkg::SRC_LV : reset_defaults_pkg::SRC_NONE;

  reset_defaults_pkg::src_e src_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_reset_ff     <= 1'b0;
      src_ff          <= reset_defaults_pkg::SRC_NONE;
      defaults_loaded <= 1'b0;
    end else if (clk_en) begin
      in_reset_ff     <= any_req;
      defaults_loaded <= take;
      if (take) begin
        src_ff <= nxt_src;
      end
    end
  end

  assign in_reset    = in_reset_ff;
  assign last_source = src_ff;

  assign program_counter_undefined = in_reset_ff || osc_wait;

  // software access is held off while any reset is active
  wire wr_ok = wr_en && !any_req && !in_reset_ff;
  wire rd_ok = rd_en && !any_req && !in_reset_ff;

  wire wr_wdog_en   = wr_ok && (wr_addr == reset_defaults_pkg::WDOG_EN_ADDR);
  wire wr_lv_ctrl   = wr_ok && (wr_addr == reset_defaults_pkg::LV_CTRL_ADDR);
  wire wr_lv_level  = wr_ok && (wr_addr == reset_defaults_pkg::LV_LEVEL_ADDR);
  wire rd_src_flags = rd_ok && (rd_addr == reset_defaults_pkg::SRC_FLAGS_ADDR);

  logic [7:0] bank_rd_data;

  default_reg_bank u_bank (
    .mclk          (mclk),
    .resetn        (resetn),
    .clk_en        (clk_en),
    .load_defaults (take),
    .wr_en         (wr_ok),
    .wr_idx        (wr_addr),
    .wr_data       (wr_data),
    .rd_idx        (rd_addr),
    .rd_data       (bank_rd_data)
  );

  reset_flag_unit u_flags (
    .mclk     (mclk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .take     (take),
    .src      (nxt_src),
    .rd_clear (rd_src_flags),
    .flags    (reset_source_flags)
  );

  // detection control kept on detector reset
  wire lv_keep = (nxt_src == reset_defaults_pkg::SRC_LV);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lowvolt_detect_control <= reset_defaults_pkg::CLR_BYTE;
      lowvolt_level_select   <= reset_defaults_pkg::CLR_BYTE;
    end else if (clk_en) begin
      if (take) begin
        lowvolt_detect_control <= lv_keep ? lowvolt_detect_control : reset_defaults_pkg::CLR_BYTE;
        lowvolt_level_select   <= lv_keep ? lowvolt_level_select : reset_defaults_pkg::CLR_BYTE;
      end else begin
        if (wr_lv_ctrl) begin
          lowvolt_detect_control <= wr_data;
        end
        if (wr_lv_level) begin
          lowvolt_level_select <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      watchdog_enable_reg <= reset_defaults_pkg::CLR_BYTE;
    end else if (clk_en) begin
      if (take) begin
        watchdog_enable_reg <= option_wdog_en;
      end else if (wr_wdog_en) begin
        watchdog_enable_reg <= wr_data;
      end
    end
  end

  // read path: local registers registered here, bank word registered in the bank
  wire [7:0] local_word = (rd_addr == reset_defaults_pkg::WDOG_EN_ADDR) ? watchdog_enable_reg :
                          (rd_addr == reset_defaults_pkg::SRC_FLAGS_ADDR) ? reset_source_flags :
                          (rd_addr == reset_defaults_pkg::LV_CTRL_ADDR) ? lowvolt_detect_control :
                          (rd_addr == reset_defaults_pkg::LV_LEVEL_ADDR) ? lowvolt_level_select :
                          reset_defaults_pkg::CLR_BYTE;
  wire       local_sel  = rd_addr >= 6'(reset_defaults_pkg::BANK_COUNT);

  logic [7:0] local_rd_ff;
  logic       local_sel_ff;
  logic       rd_valid_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      local_rd_ff  <= reset_defaults_pkg::CLR_BYTE;
      local_sel_ff <= 1'b0;
      rd_valid_ff  <= 1'b0;
    end else if (clk_en) begin
      local_rd_ff  <= local_word;
      local_sel_ff <= local_sel;
      rd_valid_ff  <= rd_ok;
    end
  end

  assign rd_data  = local_sel_ff ? local_rd_ff : bank_rd_data;
  assign rd_valid = rd_valid_ff;

endmodule

//--- verif/reset_state_defaults_asserts.sv
`timescale 1ns/1ps
module reset_state_defaults_asserts (
  // clock and reset
  input wire logic                                  mclk,
  input wire logic                                  resetn,
  // watched inputs
  input wire logic                                  osc_wait,
  input wire logic [7:0]                            option_wdog_en,
  input wire logic                                  watchdog_unit_req,
  input wire logic [reset_defaults_pkg::ADDR_W-1:0] rd_addr,
  // watched outputs
  input wire logic                                  rd_valid,
  input wire logic                                  in_reset,
  input wire logic                                  program_counter_undefined,
  input wire logic                                  defaults_loaded,
  input wire reset_defaults_pkg::src_e              last_source,
  input wire logic [7:0]                            watchdog_enable_reg,
  input wire logic [7:0]                            lowvolt_detect_control,
  input wire logic [7:0]                            lowvolt_level_select,
  input wire logic [7:0]                            reset_source_flags
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  chk_load_same_cycle: assert property ($rose(in_reset) |-> defaults_loaded)
    else $error("defaults not loaded on reset entry");
  chk_load_one_pulse: assert property (defaults_loaded |=> !defaults_loaded)
    else $error("defaults pulse longer than one cycle");
  chk_pc_undefined: assert property (program_counter_undefined == (in_reset || osc_wait))
    else $error("program counter flag wrong");
  chk_hold_in_reset: assert property (in_reset && $past(in_reset) |-> $stable(lowvolt_detect_control)
    && $stable(lowvolt_level_select) && $stable(watchdog_enable_reg) && $stable(reset_source_flags))
    else $error("state changed while reset held");
  chk_wden_option: assert property ($rose(in_reset) |-> watchdog_enable_reg == $past(option_wdog_en))
    else $error("watchdog enable not from option byte");
  chk_wdog_src_flags: assert property ($rose(in_reset) && last_source == 3'h3 |-> reset_source_flags[4]
    && reset_source_flags[0] == $past(reset_source_flags[0]) && lowvolt_detect_control == 8'h00)
    else $error("watchdog reset flags wrong");
  chk_lowvolt_keep: assert property ($rose(in_reset) && last_source == 3'h4 |-> reset_source_flags[0]
    && $stable(reset_source_flags[4]) && $stable(lowvolt_detect_control) && $stable(lowvolt_level_select))
    else $error("detector reset did not keep settings");
  chk_src_clear_all: assert property ($rose(in_reset) && last_source inside {3'h1, 3'h2, 3'h5}
    |-> reset_source_flags == 8'h00 && lowvolt_level_select == 8'h00 && lowvolt_detect_control == 8'h00)
    else $error("pin or power or default start did not clear");
  chk_flag_layout: assert property ((reset_source_flags & 8'hEE) == 8'h00)
    else $error("unused flag bits set");
  chk_read_clears: assert property (rd_valid && $past(rd_addr) == 6'h3C |-> reset_source_flags == 8'h00)
    else $error("flags not cleared by read");
  chk_entry_bound: assert property ($rose(watchdog_unit_req) && !in_reset |-> ##[1:6] in_reset)
    else $error("watchdog request not recognised in time");

  cover property ($rose(in_reset) && last_source == 3'h3);
  cover property ($rose(in_reset) && last_source == 3'h4);
  cover property (rd_valid && $past(rd_addr) == 6'h3C);
endmodule

bind reset_state_defaults reset_state_defaults_asserts u_chk (.mclk, .resetn, .osc_wait, .option_wdog_en,
  .watchdog_unit_req, .rd_addr, .rd_valid, .in_reset, .program_counter_undefined, .defaults_loaded,
  .last_source, .watchdog_enable_reg, .lowvolt_detect_control, .lowvolt_level_select, .reset_source_flags);

//--- verif/test_reset_state_defaults.sv
`timescale 1ns/1ps
module test_reset_state_defaults;
  logic                     mclk, resetn, clk_en, ext_reset_n, power_on_clear_req, watchdog_unit_req;
  logic                     lowvolt_detector_req, lowvolt_default_start_req, osc_wait, wr_en, rd_en;
  logic                     rd_valid, in_reset, program_counter_undefined, defaults_loaded;
  logic [7:0]               option_wdog_en, wr_data, rd_data, watchdog_enable_reg, lowvolt_detect_control;
  logic [7:0]               lowvolt_level_select, reset_source_flags, exp_fl;
  logic [5:0]               wr_addr, rd_addr;
  reset_defaults_pkg::src_e last_source;
  logic [7:0]               exp_reg [0:63];
  int                       bad_count, checked;
  int                       msk [12] = '{4, 8, 4, 1, 8, 16, 2, 6, 12, 17, 24, 4};
  int                       win [12] = '{3, 4, 3, 1, 4, 5, 2, 2, 3, 1, 5, 3};

  reset_state_defaults DUT (.mclk, .resetn, .clk_en, .ext_reset_n, .power_on_clear_req, .watchdog_unit_req,
    .lowvolt_detector_req, .lowvolt_default_start_req, .osc_wait, .option_wdog_en, .wr_en, .wr_addr, .wr_data,
    .rd_en, .rd_addr, .rd_data, .rd_valid, .in_reset, .program_counter_undefined, .defaults_loaded,
    .last_source, .watchdog_enable_reg, .lowvolt_detect_control, .lowvolt_level_select, .reset_source_flags);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [7:0] def_val(input int a);
    if (a inside {15, 16, 21, 33, 34} || (a >= 46 && a <= 53)) return 8'hFF;
    if (a == 17) return 8'h01;
    if (a == 22) return 8'h16;
    return 8'h00;
  endfunction

  task automatic final_report;
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic timed_out;
    bad_count++;
    $display("[ERR] %0t wait ran out", $time);
    final_report;
  endtask

  task automatic tick;
    @(posedge mclk);
    osc_wait <= 1'($urandom);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    tick;
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    tick;
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    tick;
    rd_en <= 1'b1;
    rd_addr <= a;
    tick;
    rd_en <= 1'b0;
    #1;
    cmp({7'h00, rd_valid}, 8'h01, "read valid");
    cmp(rd_data, e, "read data");
    cmp({7'h00, program_counter_undefined}, {7'h00, osc_wait}, "counter undefined flag");
  endtask

  task automatic load_model;
    for (int a = 0; a < 59; a++) exp_reg[a] = def_val(a);
  endtask

  task automatic all_write;
    logic [7:0] d;
    for (int a = 0; a < 63; a++) begin
      if (a != 60) begin
        d = 8'($urandom);
        wr(6'(a), d);
        exp_reg[a] = d;
      end
    end
  endtask

  task automatic all_read;
    for (int a = 0; a < 63; a++) begin
      if (a != 60) rd(6'(a), exp_reg[a]);
    end
  endtask

  task automatic apply(input logic [4:0] m, input int w);
    int n;
    logic [7:0] opt;
    opt = 8'($urandom);
    n = 0;
    tick;
    option_wdog_en <= opt;
    ext_reset_n <= !m[0];
    power_on_clear_req <= m[1];
    watchdog_unit_req <= m[2];
    lowvolt_detector_req <= m[3];
    lowvolt_default_start_req <= m[4];
    do begin
      tick;
      #1;
      n++;
    end while (defaults_loaded !== 1'b1 && n < 20);
    if (defaults_loaded !== 1'b1) timed_out;
    load_model;
    exp_reg[59] = opt;
    if (w == 4) exp_fl[0] = 1'b1;
    else begin
      exp_reg[61] = 8'h00;
      exp_reg[62] = 8'h00;
      if (w == 3) exp_fl[4] = 1'b1;
      else exp_fl = 8'h00;
    end
    cmp({5'h00, last_source}, 8'(w), "source");
    cmp(reset_source_flags, exp_fl, "flags");
    cmp(lowvolt_detect_control, exp_reg[61], "detect control");
    cmp(lowvolt_level_select, exp_reg[62], "level select");
    cmp(watchdog_enable_reg, opt, "watchdog enable");
    cmp({7'h00, program_counter_undefined}, 8'h01, "counter undefined in reset");
    // write while reset held must be ignored
    wr(6'h00, 8'h5A);
    tick;
    ext_reset_n <= 1'b1;
    {power_on_clear_req, watchdog_unit_req, lowvolt_detector_req, lowvolt_default_start_req} <= 4'h0;
    n = 0;
    do begin
      tick;
      #1;
      n++;
    end while (in_reset !== 1'b0 && n < 20);
    if (in_reset !== 1'b0) timed_out;
  endtask

  initial begin
    bad_count = 0;
    checked = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    ext_reset_n = 1'b1;
    {power_on_clear_req, watchdog_unit_req, lowvolt_detector_req, lowvolt_default_start_req} = 4'h0;
    {osc_wait, wr_en, rd_en} = 3'h0;
    {option_wdog_en, wr_data} = 16'h0000;
    {wr_addr, rd_addr} = 12'h000;
    void'($urandom(32'hB28589EE));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    load_model;
    {exp_reg[59], exp_reg[61], exp_reg[62], exp_fl} = 32'h00000000;
    all_read;
    rd(6'h3F, 8'h00);
    for (int i = 0; i < 12; i++) begin
      all_write;
      all_read;
      apply(5'(msk[i]), win[i]);
      all_read;
      if (i % 3 == 2) begin
        wr(6'h3C, 8'hFF);
        rd(6'h3C, exp_fl);
        exp_fl = 8'h00;
        cmp(reset_source_flags, exp_fl, "flags after read");
      end
    end
    // clock enable low: a write strobe must leave the bank untouched
    tick;
    clk_en <= 1'b0;
    wr(6'h00, 8'hA5);
    tick;
    clk_en <= 1'b1;
    rd(6'h00, exp_reg[0]);
    all_write;
    tick;
    resetn <= 1'b0;
    tick;
    tick;
    resetn <= 1'b1;
    load_model;
    {exp_reg[59], exp_reg[61], exp_reg[62], exp_fl} = 32'h00000000;
    all_read;
    cmp(reset_source_flags, exp_fl, "flags after second reset");
    final_report;
  end
endmodule
